// ==== include/mief_map.svh ====
`ifndef MIEF_MAP_SVH
`define MIEF_MAP_SVH

// ****************************************
// Register offsets
// ****************************************
`define MIEF_ADDR_W 4
`define MIEF_OFS_CORE 4'h0
`define MIEF_OFS_PIE_BASE 4'h1
`define MIEF_OFS_PIR_BASE 4'h4
`define MIEF_OFS_EDGE_CTRL 4'h7

// ****************************************
// Core control and edge control register fields
// ****************************************
`define MIEF_BIT_GIE 7
`define MIEF_BIT_PERIPH_GROUP_ENABLE 6
`define MIEF_BIT_T0IE 5
`define MIEF_BIT_EXTIE 4
`define MIEF_BIT_PCIE 3
`define MIEF_BIT_T0IF 2
`define MIEF_BIT_EXTIF 1
`define MIEF_BIT_PCIF 0
`define MIEF_BIT_EDGE_SEL 0

// ****************************************
// Implemented bit masks and reset values
// ****************************************
`define MIEF_MASK_ONE 8'hCB
`define MIEF_MASK_TWO 8'h6C
`define MIEF_MASK_THREE 8'h03
`define MIEF_RESET_BYTE 8'h00
`define MIEF_ZERO_BYTE 8'h00

// ****************************************
// Interrupt vector
// ****************************************
`define MIEF_VECTOR_ADDR 16'h0004
`define MIEF_VECTOR_RESET 16'h0000

`endif

// ==== include/mief_pkg.sv ====
package mief_pkg;

    // ****************************************
    // Shared types
    // ****************************************
    typedef logic [7:0] mief_byte_type;
    typedef logic [15:0] mief_addr16_type;

    typedef enum {
        MIEF_EDGE_FALLING,
        MIEF_EDGE_RISING
    } mief_edge_type;

endpackage : mief_pkg

// ==== sim/mief_bank_chk.sv ====
`include "mief_map.svh"

module mief_bank_chk
    import mief_pkg::*;
#(
    parameter int PIN_N = 12
) (
    input wire logic i_mclk,
    input wire logic i_resetn,
    input wire logic [`MIEF_ADDR_W-1:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] o_rdata,
    input wire logic i_timer0_ovf,
    input wire logic i_ext_pin,
    input wire logic [PIN_N-1:0] i_per_pin_change_flags,
    input wire logic [7:0] i_periph1_events,
    input wire logic [7:0] i_periph2_events,
    input wire logic [7:0] i_periph3_events,
    input wire logic i_return_from_irq_instr,
    input wire logic o_irq_req,
    input wire logic o_irq_entry,
    input wire logic [15:0] o_vector_addr,
    input wire logic o_wake,
    input wire logic o_global_irq_enable
);
    timeunit 1ns;
    timeprecision 1ps;

    // **********
    // Readable bits per index
    // **********
    logic [7:0] rmask;
    always_comb begin
        case (i_addr)
            4'h0: rmask = 8'hFF;
            4'h1, 4'h4: rmask = 8'hCB;
            4'h2, 4'h5: rmask = 8'h6C;
            4'h3, 4'h6: rmask = 8'h03;
            4'h7: rmask = 8'h01;
            default: rmask = 8'h00;
        endcase
    end

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_resetn);

    property p_req_gie;
        o_irq_req |-> $past(o_global_irq_enable);
    endproperty
    a_req_gie: assert property (p_req_gie) else $error("request without global enable");
    property p_entry_vec;
        o_irq_entry |-> !o_global_irq_enable && o_vector_addr == 16'h0004;
    endproperty
    a_entry_vec: assert property (p_entry_vec) else $error("entry state wrong");
    property p_gie_src;
        $rose(o_global_irq_enable) |-> $past(i_return_from_irq_instr)
            || $past(i_wr && i_addr == 4'h0 && i_wdata[7]);
    endproperty
    a_gie_src: assert property (p_gie_src) else $error("global enable set without return or write");
    property p_req_once;
        o_irq_req |=> !o_irq_req;
    endproperty
    a_req_once: assert property (p_req_once) else $error("request held after entry");
    property p_ret;
        i_return_from_irq_instr |=> o_global_irq_enable || o_irq_entry;
    endproperty
    a_ret: assert property (p_ret) else $error("return left global enable clear");
    property p_rd_mask;
        i_rd |=> (o_rdata & ~$past(rmask)) == 8'h00;
    endproperty
    a_rd_mask: assert property (p_rd_mask) else $error("unimplemented bit read as one");
    property p_sum_set;
        (|i_per_pin_change_flags) [*2] ##0 (i_rd && i_addr == 4'h0) |=> o_rdata[0];
    endproperty
    a_sum_set: assert property (p_sum_set) else $error("change summary low");
    property p_sum_clr;
        (i_per_pin_change_flags == '0) [*2] ##0 (i_rd && i_addr == 4'h0) |=> !o_rdata[0];
    endproperty
    a_sum_clr: assert property (p_sum_clr) else $error("change summary high");
    property p_wake;
        o_irq_req |-> o_wake;
    endproperty
    a_wake: assert property (p_wake) else $error("request without enabled flag");
endmodule : mief_bank_chk

// ==== sim/mief_cpu_model.sv ====
module mief_cpu_model #(
    parameter int SERVICE_CYC = 12
) (
    input wire logic i_mclk,
    input wire logic i_resetn,
    input wire logic i_irq_entry,
    output logic o_return
);
    timeunit 1ns;
    timeprecision 1ps;

    // **********
    // Service routine then return
    // **********
    logic busy_q;
    logic [7:0] cnt_q;
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            busy_q <= 1'b0;
            cnt_q <= 8'h00;
            o_return <= 1'b0;
        end else begin
            o_return <= 1'b0;
            if (i_irq_entry) begin
                busy_q <= 1'b1;
                cnt_q <= 8'h00;
            end else if (busy_q) begin
                cnt_q <= cnt_q + 8'h01;
                if (cnt_q == SERVICE_CYC[7:0]) begin
                    busy_q <= 1'b0;
                    o_return <= 1'b1;
                end
            end
        end
    end
endmodule : mief_cpu_model

// ==== sim/tb_mief_bank.sv ====
module tb_mief_bank
    import mief_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic mclk, resetn, wr, rd, t0, pin, ret, req, entry, wake, global_irq_enable;
    logic [3:0] addr;
    mief_byte_type wdata, rdata, ev1, ev2, ev3;
    logic [11:0] pcf;
    logic [15:0] vec;
    mief_byte_type mask [9] = '{8'hFF, 8'hCB, 8'h6C, 8'h03, 8'hCB, 8'h6C, 8'h03, 8'h01, 8'h00};
    int n_mismatch = 0;
    int num_checks = 0;
    int n_entry = 0;
    int cyc = 0;

    mief_bank #(.PIN_N(12), .PERIPH_N(3)) dut_u (
        .i_mclk(mclk), .i_resetn(resetn), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
        .o_rdata(rdata), .i_timer0_ovf(t0), .i_ext_pin(pin), .i_per_pin_change_flags(pcf),
        .i_periph1_events(ev1), .i_periph2_events(ev2), .i_periph3_events(ev3),
        .i_return_from_irq_instr(ret), .o_irq_req(req), .o_irq_entry(entry),
        .o_vector_addr(vec), .o_wake(wake), .o_global_irq_enable(global_irq_enable));
    mief_cpu_model #(.SERVICE_CYC(12)) cpu_u (.i_mclk(mclk), .i_resetn(resetn), .i_irq_entry(entry), .o_return(ret));

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        cyc++;
        if (entry === 1'b1) n_entry++;
        if (cyc == 3000) begin
            n_mismatch++;
            conclude();
        end
    end

    // **********
    // Access and compare tasks
    // **********
    task automatic chk(input mief_byte_type got, input mief_byte_type exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr_reg(input logic [3:0] a, input mief_byte_type d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_chk(input logic [3:0] a, input mief_byte_type exp);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1 chk(rdata, exp);
    endtask : rd_chk
    task automatic wait_entries(input int want);
        for (int i = 0; i < 20 && n_entry < want; i++) @(posedge mclk);
        #1 chk(8'(n_entry), 8'(want));
    endtask : wait_entries
    task automatic pin_step(input logic lvl, input mief_byte_type exp);
        @(posedge mclk);
        pin <= lvl;
        repeat (8) @(posedge mclk);
        rd_chk(4'h0, exp);
    endtask : pin_step
    task automatic conclude;
        $display("Comparisons %0d, mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : conclude

    // **********
    // Test sequence
    // **********
    initial begin
        resetn = 1'b0;
        {addr, wdata, wr, rd, t0, pin, pcf, ev1, ev2, ev3} = '0;
        repeat (5) @(posedge mclk);
        resetn <= 1'b1;
        for (int a = 0; a < 9; a++) rd_chk(4'(a), 8'h00);
        chk(vec[7:0], 8'h00);
        $display("reset values done");
        for (int a = 1; a < 9; a++) begin
            wr_reg(4'(a), 8'hFF);
            rd_chk(4'(a), mask[a]);
        end
        wr_reg(4'h0, 8'h7F);
        rd_chk(4'h0, 8'h7E);
        for (int a = 0; a < 8; a++) wr_reg(4'(a), 8'h00);
        $display("access masks done");
        @(posedge mclk);
        {ev1, ev2, ev3, t0} <= {8'hFF, 8'hFF, 8'hFF, 1'b1};
        @(posedge mclk);
        {ev1, ev2, ev3, t0} <= '0;
        rd_chk(4'h4, 8'hCB);
        rd_chk(4'h5, 8'h6C);
        rd_chk(4'h6, 8'h03);
        rd_chk(4'h0, 8'h04);
        wr_reg(4'h0, 8'hC4);
        repeat (4) @(posedge mclk);
        #1 chk({7'h0, req}, 8'h00);
        for (int a = 0; a < 7; a += (a == 0) ? 4 : 1) wr_reg(4'(a), 8'h00);
        $display("flags without enables done");
        @(posedge mclk);
        {addr, wdata, wr, ev1} <= {4'h4, 8'h00, 1'b1, 8'h01};
        @(posedge mclk);
        {wr, ev1} <= '0;
        rd_chk(4'h4, 8'h01);
        wr_reg(4'h1, 8'h01);
        wr_reg(4'h0, 8'h80);
        repeat (4) @(posedge mclk);
        #1 chk({6'h0, req, wake}, 8'h01);
        wr_reg(4'h0, 8'hC0);
        wait_entries(1);
        rd_chk(4'h0, 8'h40);
        chk(vec[15:8], 8'h00);
        chk(vec[7:0], 8'h04);
        wr_reg(4'h4, 8'h00);
        for (int i = 0; i < 30 && global_irq_enable !== 1'b1; i++) @(posedge mclk);
        rd_chk(4'h0, 8'hC0);
        wait_entries(1);
        $display("peripheral entry done");
        wr_reg(4'h0, 8'hA0);
        @(posedge mclk);
        t0 <= 1'b1;
        @(posedge mclk);
        t0 <= 1'b0;
        wait_entries(2);
        wr_reg(4'h0, 8'h20);
        for (int i = 0; i < 30 && global_irq_enable !== 1'b1; i++) @(posedge mclk);
        wait_entries(2);
        wr_reg(4'h0, 8'h00);
        $display("timer entry done");
        wr_reg(4'h7, 8'h01);
        pin_step(1'b1, 8'h02);
        wr_reg(4'h0, 8'h00);
        pin_step(1'b0, 8'h00);
        wr_reg(4'h7, 8'h00);
        pin_step(1'b1, 8'h00);
        pin_step(1'b0, 8'h02);
        wr_reg(4'h0, 8'h00);
        $display("pin edge done");
        @(posedge mclk);
        pcf <= 12'h008;
        rd_chk(4'h0, 8'h01);
        wr_reg(4'h0, 8'h00);
        rd_chk(4'h0, 8'h01);
        @(posedge mclk);
        pcf <= 12'h000;
        rd_chk(4'h0, 8'h00);
        $display("change summary done");
        wr_reg(4'h2, 8'hFF);
        @(posedge mclk);
        resetn <= 1'b0;
        repeat (3) @(posedge mclk);
        resetn <= 1'b1;
        rd_chk(4'h2, 8'h00);
        chk({7'h0, global_irq_enable}, 8'h00);
        $display("second reset done");
        conclude();
    end
endmodule : tb_mief_bank

bind mief_bank mief_bank_chk #(.PIN_N(PIN_N)) chk_u (
    .i_mclk(i_mclk), .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .i_timer0_ovf(i_timer0_ovf), .i_ext_pin(i_ext_pin),
    .i_per_pin_change_flags(i_per_pin_change_flags), .i_periph1_events(i_periph1_events),
    .i_periph2_events(i_periph2_events), .i_periph3_events(i_periph3_events),
    .i_return_from_irq_instr(i_return_from_irq_instr), .o_irq_req(o_irq_req), .o_irq_entry(o_irq_entry),
    .o_vector_addr(o_vector_addr), .o_wake(o_wake), .o_global_irq_enable(o_global_irq_enable));

// ==== verilog/mief_bank.sv ====
// Operation
// R1 - Global enable gates every interrupt request
// R2 - Group enable gates all peripheral interrupts
// R3 - Flags set regardless of any enable
// R4 - Software clears flags before enabling sources
// R5 - Core enables for timer0, pin, change
// R6 - Timer0 flag set on count overflow
// R7 - Pin flag set on external pin event
// R8 - Change summary is OR of pin flags
// R9 - Change summary read-only, writes ignored
// R10 - Enable register one holds five enables
// R11 - Request register one mirrors enable positions
// R12 - Enable register two holds four enables
// R13 - Request register two holds four flags
// R14 - Enable register three holds logic cells
// R15 - Unimplemented bits ignore writes, read zero
// R16 - All bits reset to zero
// R17 - Entry clears global enable, loads vector
// R18 - Return instruction sets global enable again
// R19 - Edge select picks rising or falling
// R20 - Request register three holds cell flags
// R21 - Request combines core and gated peripheral
// R22 - Event set wins over software clear
//
// The strobed register port and the register offsets were decided locally.
`include "mief_map.svh"

module mief_bank
    import mief_pkg::*;
#(
    parameter int PIN_N = 12,
    parameter int PERIPH_N = 3
) (
    input wire logic i_mclk,
    input wire logic i_resetn,
    input wire logic [`MIEF_ADDR_W-1:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    input wire logic i_timer0_ovf,
    input wire logic i_ext_pin,
    input wire logic [PIN_N-1:0] i_per_pin_change_flags,
    input wire logic [7:0] i_periph1_events,
    input wire logic [7:0] i_periph2_events,
    input wire logic [7:0] i_periph3_events,
    input wire logic i_return_from_irq_instr,
    output logic o_irq_req,
    output logic o_irq_entry,
    output logic [15:0] o_vector_addr,
    output logic o_wake,
    output logic o_global_irq_enable
);

    // ****************************************
    // Implemented bit mask per peripheral register
    // ****************************************
    function automatic mief_byte_type periph_mask(input int idx);
        mief_byte_type m;
        m = `MIEF_ZERO_BYTE;
        case (idx)
            0: begin
                m = `MIEF_MASK_ONE;
            end
            1: begin
                m = `MIEF_MASK_TWO;
            end
            2: begin
                m = `MIEF_MASK_THREE;
            end
            default: begin
                m = `MIEF_ZERO_BYTE;
            end
        endcase
        return m;
    endfunction : periph_mask

    // ****************************************
    // Core control state
    // ****************************************
    logic global_irq_enable_q;
    logic periph_group_enable_q;
    logic timer0_ovf_enable_q;
    logic ext_pin_irq_enable_q;
    logic pin_change_enable_q;
    logic timer0_ovf_flag_q;
    logic ext_pin_irq_flag_q;
    logic pin_change_summary_flag_q;
    logic ext_pin_edge_select_q;

    mief_byte_type pie_q [PERIPH_N];
    mief_byte_type pir_q [PERIPH_N];
    mief_byte_type periph_events [PERIPH_N];
    logic [PERIPH_N-1:0] periph_pending;
    mief_byte_type periph_chain [PERIPH_N+1];
    mief_byte_type core_byte;
    mief_byte_type edge_byte;

    logic core_wr;
    logic edge_wr;
    logic ext_pin_event;
    logic core_pending;
    logic any_periph_pending;
    logic irq_req_d;
    logic wake_d;

    logic irq_req_q;
    logic irq_entry_q;
    mief_addr16_type vector_addr_q;
    logic wake_q;
    mief_byte_type rdata_q;

    assign periph_events[0] = i_periph1_events;
    assign periph_events[1] = i_periph2_events;
    assign periph_events[2] = i_periph3_events;
    assign periph_chain[0] = `MIEF_ZERO_BYTE;

    assign core_wr = i_wr && (i_addr == `MIEF_OFS_CORE);
    assign edge_wr = i_wr && (i_addr == `MIEF_OFS_EDGE_CTRL);

    // ****************************************
    // External pin edge detection
    // ****************************************
    mief_pin_edge u_pin_edge (
        .i_mclk(i_mclk),
        .i_resetn(i_resetn),
        .i_pin(i_ext_pin),
        .i_edge_sel(ext_pin_edge_select_q),
        .o_event(ext_pin_event)
    );

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            ext_pin_edge_select_q <= 1'b0; // R16
        end else if (edge_wr) begin
            ext_pin_edge_select_q <= i_wdata[`MIEF_BIT_EDGE_SEL]; // R19
        end
    end

    // ****************************************
    // Global enable
    // ****************************************
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            global_irq_enable_q <= 1'b0; // R16
        end else if (irq_req_d) begin
            global_irq_enable_q <= 1'b0; // R17
        end else if (i_return_from_irq_instr) begin
            global_irq_enable_q <= 1'b1; // R18
        end else if (core_wr) begin
            global_irq_enable_q <= i_wdata[`MIEF_BIT_GIE];
        end
    end

    // ****************************************
    // Core enables
    // ****************************************
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            periph_group_enable_q <= 1'b0; // R16
            timer0_ovf_enable_q <= 1'b0;
            ext_pin_irq_enable_q <= 1'b0;
            pin_change_enable_q <= 1'b0;
        end else if (core_wr) begin
            periph_group_enable_q <= i_wdata[`MIEF_BIT_PERIPH_GROUP_ENABLE]; // R2
            timer0_ovf_enable_q <= i_wdata[`MIEF_BIT_T0IE]; // R5
            ext_pin_irq_enable_q <= i_wdata[`MIEF_BIT_EXTIE]; // R5
            pin_change_enable_q <= i_wdata[`MIEF_BIT_PCIE]; // R5
        end
    end

    // ****************************************
    // Core flags
    // ****************************************
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            timer0_ovf_flag_q <= 1'b0; // R16
        end else if (i_timer0_ovf) begin
            timer0_ovf_flag_q <= 1'b1; // R6 R3 R22
        end else if (core_wr) begin
            timer0_ovf_flag_q <= i_wdata[`MIEF_BIT_T0IF];
        end
    end

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            ext_pin_irq_flag_q <= 1'b0; // R16
        end else if (ext_pin_event) begin
            ext_pin_irq_flag_q <= 1'b1; // R7 R3 R22
        end else if (core_wr) begin
            ext_pin_irq_flag_q <= i_wdata[`MIEF_BIT_EXTIF];
        end
    end

    // Summary follows the per-pin flags only; bus writes never reach it
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            pin_change_summary_flag_q <= 1'b0; // R16
        end else begin
            pin_change_summary_flag_q <= |i_per_pin_change_flags; // R8 R9
        end
    end

    // ****************************************
    // Peripheral enable and request registers
    // ****************************************
    generate
        for (genvar g = 0; g < PERIPH_N; g++) begin : g_periph
            logic pie_hit;
            logic pir_hit;
            logic pie_wr;
            logic pir_wr;
            mief_byte_type view;

            assign pie_hit = (i_addr == (`MIEF_OFS_PIE_BASE + `MIEF_ADDR_W'(g)));
            assign pir_hit = (i_addr == (`MIEF_OFS_PIR_BASE + `MIEF_ADDR_W'(g)));
            assign pie_wr = i_wr && pie_hit;
            assign pir_wr = i_wr && pir_hit;

            always_ff @(posedge i_mclk or negedge i_resetn) begin
                if (!i_resetn) begin
                    pie_q[g] <= `MIEF_RESET_BYTE; // R16
                end else if (pie_wr) begin
                    pie_q[g] <= i_wdata & periph_mask(g); // R10 R12 R14 R15
                end
            end

            always_ff @(posedge i_mclk or negedge i_resetn) begin
                if (!i_resetn) begin
                    pir_q[g] <= `MIEF_RESET_BYTE; // R16
                end else if (pir_wr) begin
                    pir_q[g] <= (i_wdata | periph_events[g]) & periph_mask(g); // R22 R15
                end else begin
                    pir_q[g] <= (pir_q[g] | periph_events[g]) & periph_mask(g); // R3 R11 R13 R20
                end
            end

            assign periph_pending[g] = |(pie_q[g] & pir_q[g]);
            assign view = pie_hit ? pie_q[g] : (pir_hit ? pir_q[g] : `MIEF_ZERO_BYTE);
            assign periph_chain[g+1] = periph_chain[g] | view;
        end
    endgenerate

    // ****************************************
    // Request combination
    // ****************************************
    always_comb begin
        core_pending = (timer0_ovf_enable_q && timer0_ovf_flag_q)
            || (ext_pin_irq_enable_q && ext_pin_irq_flag_q)
            || (pin_change_enable_q && pin_change_summary_flag_q); // R5
        any_periph_pending = periph_group_enable_q && (|periph_pending); // R2
        wake_d = core_pending || (|periph_pending);
        irq_req_d = global_irq_enable_q && (core_pending || any_periph_pending); // R1 R21
    end

    // ****************************************
    // Core hand-off
    // ****************************************
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            irq_req_q <= 1'b0;
        end else begin
            irq_req_q <= irq_req_d; // R1
        end
    end

    // ****************************************
    // Entry pulse
    // ****************************************
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            irq_entry_q <= 1'b0;
        end else begin
            irq_entry_q <= irq_req_d; // R17
        end
    end

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            vector_addr_q <= `MIEF_VECTOR_RESET;
        end else if (irq_req_d) begin
            vector_addr_q <= `MIEF_VECTOR_ADDR; // R17
        end
    end

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            wake_q <= 1'b0;
        end else begin
            wake_q <= wake_d;
        end
    end

    // ****************************************
    // Readable register bytes
    // ****************************************
    always_comb begin
        core_byte = `MIEF_ZERO_BYTE;
        core_byte[`MIEF_BIT_GIE] = global_irq_enable_q;
        core_byte[`MIEF_BIT_PERIPH_GROUP_ENABLE] = periph_group_enable_q;
        core_byte[`MIEF_BIT_T0IE] = timer0_ovf_enable_q;
        core_byte[`MIEF_BIT_EXTIE] = ext_pin_irq_enable_q;
        core_byte[`MIEF_BIT_PCIE] = pin_change_enable_q;
        core_byte[`MIEF_BIT_T0IF] = timer0_ovf_flag_q;
        core_byte[`MIEF_BIT_EXTIF] = ext_pin_irq_flag_q;
        core_byte[`MIEF_BIT_PCIF] = pin_change_summary_flag_q;
        edge_byte = `MIEF_ZERO_BYTE;
        edge_byte[`MIEF_BIT_EDGE_SEL] = ext_pin_edge_select_q;
    end

    // ****************************************
    // Register read port
    // ****************************************
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            rdata_q <= `MIEF_ZERO_BYTE;
        end else if (i_rd) begin
            case (i_addr)
                `MIEF_OFS_CORE: begin
                    rdata_q <= core_byte;
                end
                `MIEF_OFS_EDGE_CTRL: begin
                    rdata_q <= edge_byte;
                end
                default: begin
                    rdata_q <= periph_chain[PERIPH_N]; // R15
                end
            endcase
        end else begin
            rdata_q <= `MIEF_ZERO_BYTE;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign o_rdata = rdata_q;
    assign o_irq_req = irq_req_q;
    assign o_irq_entry = irq_entry_q;
    assign o_vector_addr = vector_addr_q;
    assign o_wake = wake_q;
    assign o_global_irq_enable = global_irq_enable_q;

endmodule : mief_bank

// ==== verilog/mief_pin_edge.sv ====
`include "mief_map.svh"

module mief_pin_edge
    import mief_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_resetn,
    input wire logic i_pin,
    input wire logic i_edge_sel,
    output logic o_event
);

    // ****************************************
    // Three stage pin synchroniser
    // ****************************************
    logic sync1_q;
    logic sync2_q;
    logic sync3_q;
    logic level_q;
    logic event_q;
    mief_edge_type edge_mode;

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            sync3_q <= 1'b0;
        end else begin
            sync1_q <= i_pin;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    // ****************************************
    // Accepted level, taken when two stages agree
    // ****************************************
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            level_q <= 1'b0;
        end else if (sync2_q == sync3_q) begin
            level_q <= sync3_q;
        end
    end

    // ****************************************
    // Edge pick by edge select
    // ****************************************
    always_comb begin
        edge_mode = i_edge_sel ? MIEF_EDGE_RISING : MIEF_EDGE_FALLING;
    end

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            event_q <= 1'b0;
        end else if (sync2_q == sync3_q && sync3_q != level_q) begin
            case (edge_mode)
                MIEF_EDGE_RISING: begin
                    event_q <= sync3_q; // R19
                end
                MIEF_EDGE_FALLING: begin
                    event_q <= !sync3_q; // R19
                end
                default: begin
                    event_q <= 1'b0;
                end
            endcase
        end else begin
            event_q <= 1'b0;
        end
    end

    assign o_event = event_q;

endmodule : mief_pin_edge
